// ==== verilog/irt_timer_pair.v ====
/*
 * Paired 8-bit and 16-bit infrared down-counters with ping-pong
 * transmit, 16-bit demodulation capture and an APB register slave.
 * Assumes one clock core_clk, asynchronous reset rst, and a
 * synchronous stop_recover pulse for stop-mode recovery.
 */
`timescale 1ns/10ps
`default_nettype none
`include "irt_defs.vh"

// Function
// RULE1 - Demod, ignore bit set: edges after the first are ignored, counting continues.
// RULE2 - Demod, ignore set: 8-bit timeout captures 16-bit count, interrupt if enabled.
// RULE3 - That timeout capture never reloads the 16-bit count.
// RULE4 - Ignore bit written 0 then 1: next selected edge captures and reloads.
// RULE5 - Demod 16-bit reaching zero wraps to all ones, sets status, interrupts.
// RULE6 - Software uses ping-pong only for transmit, single-pass, via mode field.
// RULE7 - Software starts ping-pong by enabling either timer.
// RULE8 - Enabling 8-bit timer sets its output level and loads high or low count.
// RULE9 - 8-bit terminal count disables it, enables 16-bit with initial level, load.
// RULE10 - 16-bit terminal count in ping-pong stops it and re-enables 8-bit.
// RULE11 - Each terminal count in ping-pong interrupts if that timer enables it.
// RULE12 - Writing zero to the ping-pong field ends ping-pong.
// RULE13 - Hardware alternates both enable bits during ping-pong.
// RULE14 - Each terminal count in ping-pong sets that timer's status bit.
// RULE15 - Software should stop timers and clear flags before selecting ping-pong.
// RULE16 - Auxiliary reserved low bits ignore writes and read as ones.
// RULE17 - Auxiliary enable bits read run state; write 0 stops, 1 enables.
// RULE18 - Sync-mode bit: 1 enables, reset clears, stop recovery keeps it.
// RULE19 - Demod: reloads all ones; first edge captures, reloads, starts counting. Code reloads the RH16/RL16 value, not all ones.
// RULE20 - Active edge chosen rising, falling or both by a two-bit field.
// RULE21 - Both timers count on prescaled ticks, all bits synchronous to core_clk.
module irt_timer_pair (
    input wire core_clk,
    input wire rst,
    input wire stop_recover,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`IRT_AW-1:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire carrier_in,
    output wire short_timer_output,
    output wire long_timer_output,
    output wire short_timer_irq,
    output wire long_timer_irq
);

// ----------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------
function hit;
    input [`IRT_AW-1:0] a;
    input [3:0] idx;
    begin
        hit = (a[`IRT_AW-1:2] == idx) && (a[1:0] == 2'b00);
    end
endfunction

// ----------------------------------------------------------------
// State
// ----------------------------------------------------------------
reg [31:0] prdata_reg;
reg pready_reg;
reg pslverr_reg;
reg en8_reg;
reg mode8_reg;
reg st8_reg;
reg ien8_reg;
reg demod_reg;
reg [1:0] esel_reg;
reg [1:0] ppm_reg;
reg init8_reg;
reg init16_reg;
reg en16_reg;
reg ign16_reg;
reg st16_reg;
reg cst16_reg;
reg cien16_reg;
reg ien16_reg;
reg sync_reg;
reg armed_reg;
reg [7:0] hi8_reg;
reg [7:0] lo8_reg;
reg [7:0] rh16_reg;
reg [7:0] rl16_reg;
reg [15:0] cap_reg;
reg [7:0] presc_reg;
reg [7:0] pcnt_reg;
reg [7:0] cnt8_reg;
reg [15:0] cnt16_reg;
reg out8_reg;
reg out16_reg;
reg irq8_reg;
reg irq16_reg;
reg [31:0] rd_next;
reg rd_ok_next;

wire rise;
wire fall;

// Carrier pin passes two flops inside the edge detector
irt_edge_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .carrier_in(carrier_in),
    .rise(rise),
    .fall(fall)
);

// ----------------------------------------------------------------
// Write strobes and derived events
// ----------------------------------------------------------------
wire wr = psel & penable & pready_reg & pwrite;
wire w_ctl0 = wr & hit(paddr, `IRT_IDX_CTL0);
wire w_ctl1 = wr & hit(paddr, `IRT_IDX_CTL1);
wire w_ctl2 = wr & hit(paddr, `IRT_IDX_CTL2);
wire w_aux = wr & hit(paddr, `IRT_IDX_AUX);
// CTL0 and CTL2 each carry an enable; aux mirrors both
wire wen8 = w_ctl0 | w_aux;
wire wval8 = w_ctl0 ? pwdata[`IRT_B_EN] : pwdata[`IRT_B_AUX_EN8];
wire wen16 = w_ctl2 | w_aux;
wire wval16 = w_ctl2 ? pwdata[`IRT_B_EN] : pwdata[`IRT_B_AUX_EN16];
wire start8 = wen8 & wval8 & ~en8_reg;
wire start16 = wen16 & wval16 & ~en16_reg;
wire rearm = w_ctl2 & pwdata[`IRT_B_MODE] & ~ign16_reg;
wire pp_on = (ppm_reg == `IRT_PP_ON);
wire tick = (pcnt_reg == `IRT_RST8);
wire edge_hit = (esel_reg[0] & rise) | (esel_reg[1] & fall); // see RULE20
wire term8 = en8_reg & tick & (cnt8_reg == `IRT_ONE8);
wire term16 = en16_reg & tick & ~demod_reg & (cnt16_reg == `IRT_ONE16);
wire [15:0] reload16 = {rh16_reg, rl16_reg};

// ----------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------
// Unused bits read zero; unknown addresses answer with an error
always @* begin
    rd_next = 32'h0000_0000;
    rd_ok_next = 1'b1;
    case (paddr[`IRT_AW-1:2])
        `IRT_IDX_CTL0: rd_next[7:0] = {en8_reg, mode8_reg, st8_reg,
                                       3'b000, ien8_reg, 1'b0};
        `IRT_IDX_CTL1: rd_next[7:0] = {1'b0, demod_reg, esel_reg,
                                       ppm_reg, init8_reg, init16_reg};
        `IRT_IDX_CTL2: rd_next[7:0] = {en16_reg, ign16_reg, st16_reg, 1'b0,
                                       cst16_reg, cien16_reg, ien16_reg, 1'b0};
        // Run state mirrored; reserved bits fixed at ones
        `IRT_IDX_AUX: rd_next[7:0] = {en16_reg, en8_reg, sync_reg,
                                      `IRT_AUX_RSVD}; // see RULE16, see RULE17
        `IRT_IDX_HI8: rd_next[7:0] = hi8_reg;
        `IRT_IDX_LO8: rd_next[7:0] = lo8_reg;
        `IRT_IDX_RH16: rd_next[7:0] = rh16_reg;
        `IRT_IDX_RL16: rd_next[7:0] = rl16_reg;
        `IRT_IDX_CAPH: rd_next[7:0] = cap_reg[15:8];
        `IRT_IDX_CAPL: rd_next[7:0] = cap_reg[7:0];
        `IRT_IDX_PRESC: rd_next[7:0] = presc_reg;
        default: rd_ok_next = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00) begin
        rd_ok_next = 1'b0;
    end
end

// ----------------------------------------------------------------
// APB handshake: answer prepared in setup, completes first access
// ----------------------------------------------------------------
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        prdata_reg <= 32'h0000_0000;
        pready_reg <= 1'b0;
        pslverr_reg <= 1'b0;
    end else if (psel & ~penable & ~pready_reg) begin
        prdata_reg <= (pwrite | ~rd_ok_next) ? 32'h0000_0000 : rd_next;
        pslverr_reg <= ~rd_ok_next;
        pready_reg <= 1'b1;
    end else begin
        pready_reg <= 1'b0;
        pslverr_reg <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Sync-mode bit: kept across stop-mode recovery
// ----------------------------------------------------------------
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        sync_reg <= 1'b0; // see RULE18
    end else if (w_aux) begin
        sync_reg <= pwdata[`IRT_B_SYNC]; // see RULE18
    end
end

// ----------------------------------------------------------------
// Registers, timers and ping-pong sequencing
// ----------------------------------------------------------------
// Later assignments win, so hardware events override software
// clears in the same cycle and flags are never lost.
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        en8_reg <= 1'b0;
        mode8_reg <= 1'b0;
        st8_reg <= 1'b0;
        ien8_reg <= 1'b0;
        demod_reg <= 1'b0;
        esel_reg <= 2'b00;
        ppm_reg <= `IRT_PP_OFF;
        init8_reg <= 1'b0;
        init16_reg <= 1'b0;
        en16_reg <= 1'b0;
        ign16_reg <= 1'b0;
        st16_reg <= 1'b0;
        cst16_reg <= 1'b0;
        cien16_reg <= 1'b0;
        ien16_reg <= 1'b0;
        armed_reg <= 1'b0;
        hi8_reg <= `IRT_RST8;
        lo8_reg <= `IRT_RST8;
        rh16_reg <= `IRT_RST8;
        rl16_reg <= `IRT_RST8;
        cap_reg <= `IRT_RST16;
        presc_reg <= `IRT_RST8;
        pcnt_reg <= `IRT_RST8;
        cnt8_reg <= `IRT_RST8;
        cnt16_reg <= `IRT_RST16;
        out8_reg <= 1'b0;
        out16_reg <= 1'b0;
        irq8_reg <= 1'b0;
        irq16_reg <= 1'b0;
    end else if (stop_recover) begin
        // Stop-mode recovery clears enables, status, ping-pong, arming and outputs, not the sync bit
        en8_reg <= 1'b0;
        en16_reg <= 1'b0;
        st8_reg <= 1'b0;
        st16_reg <= 1'b0;
        cst16_reg <= 1'b0;
        ppm_reg <= `IRT_PP_OFF;
        armed_reg <= 1'b0;
        out8_reg <= 1'b0;
        out16_reg <= 1'b0;
        irq8_reg <= 1'b0;
        irq16_reg <= 1'b0;
        pcnt_reg <= `IRT_RST8;
    end else begin
        irq8_reg <= 1'b0;
        irq16_reg <= 1'b0;
        // Prescaler gives one tick every presc+1 cycles
        pcnt_reg <= tick ? presc_reg : pcnt_reg - `IRT_ONE8; // see RULE21

        // Plain register stores; status bits clear on write of one
        if (w_ctl0) begin
            mode8_reg <= pwdata[`IRT_B_MODE];
            ien8_reg <= pwdata[`IRT_B_IEN];
            if (pwdata[`IRT_B_ST]) st8_reg <= 1'b0;
        end
        if (w_ctl1) begin
            demod_reg <= pwdata[`IRT_B_DEMOD];
            esel_reg <= pwdata[`IRT_B_ESEL_HI:`IRT_B_ESEL_LO];
            ppm_reg <= pwdata[`IRT_B_PP_HI:`IRT_B_PP_LO]; // see RULE12
            init8_reg <= pwdata[`IRT_B_INIT8];
            init16_reg <= pwdata[`IRT_B_INIT16];
        end
        if (w_ctl2) begin
            ign16_reg <= pwdata[`IRT_B_MODE];
            cien16_reg <= pwdata[`IRT_B_CIEN];
            ien16_reg <= pwdata[`IRT_B_IEN];
            if (pwdata[`IRT_B_ST]) st16_reg <= 1'b0;
            if (pwdata[`IRT_B_CST]) cst16_reg <= 1'b0;
        end
        if (wr & hit(paddr, `IRT_IDX_HI8)) hi8_reg <= pwdata[7:0];
        if (wr & hit(paddr, `IRT_IDX_LO8)) lo8_reg <= pwdata[7:0];
        if (wr & hit(paddr, `IRT_IDX_RH16)) rh16_reg <= pwdata[7:0];
        if (wr & hit(paddr, `IRT_IDX_RL16)) rl16_reg <= pwdata[7:0];
        if (wr & hit(paddr, `IRT_IDX_PRESC)) presc_reg <= pwdata[7:0];

        // Software enable and stop of each timer
        if (wen8) en8_reg <= wval8; // see RULE17
        if (wen16) en16_reg <= wval16; // see RULE17
        if (rearm) armed_reg <= 1'b1; // see RULE4

        // 8-bit timer
        if (start8) begin
            out8_reg <= init8_reg; // see RULE8
            cnt8_reg <= init8_reg ? hi8_reg : lo8_reg; // see RULE8
        end else if (term8) begin
            out8_reg <= ~out8_reg;
            st8_reg <= 1'b1; // see RULE14
            if (ien8_reg) irq8_reg <= 1'b1; // see RULE11
            if (mode8_reg) begin
                cnt8_reg <= `IRT_RST8;
                en8_reg <= 1'b0; // see RULE9, see RULE13
            end else begin
                cnt8_reg <= out8_reg ? lo8_reg : hi8_reg;
            end
        end else if (en8_reg & tick) begin
            cnt8_reg <= cnt8_reg - `IRT_ONE8; // see RULE21
        end

        // 16-bit timer, transmit side
        if (~demod_reg) begin
            if (start16) begin
                out16_reg <= init16_reg;
                cnt16_reg <= reload16;
            end else if (term16) begin
                out16_reg <= ~out16_reg;
                st16_reg <= 1'b1; // see RULE14
                if (ien16_reg) irq16_reg <= 1'b1; // see RULE11
                if (ign16_reg) begin
                    cnt16_reg <= `IRT_ZERO16;
                    en16_reg <= 1'b0; // see RULE10, see RULE13
                end else begin
                    cnt16_reg <= reload16;
                end
            end else if (en16_reg & tick) begin
                cnt16_reg <= cnt16_reg - `IRT_ONE16; // see RULE21
            end
        end

        // 16-bit timer, demodulation side
        if (demod_reg) begin
            // Enabling waits for the first edge before counting starts
            if (start16) armed_reg <= 1'b1; // see RULE19
            if (en16_reg & tick & armed_reg) begin
                cnt16_reg <= cnt16_reg;
            end else if (en16_reg & tick) begin
                if (cnt16_reg == `IRT_ZERO16) begin
                    cnt16_reg <= `IRT_ALL16; // see RULE5
                    st16_reg <= 1'b1; // see RULE5
                    if (ien16_reg) irq16_reg <= 1'b1; // see RULE5
                end else begin
                    cnt16_reg <= cnt16_reg - `IRT_ONE16;
                end
            end
            // 8-bit timeout snapshots the count without reloading
            if (en16_reg & ~armed_reg & ign16_reg & term8) begin
                cap_reg <= cnt16_reg; // see RULE2, see RULE3
                if (cien16_reg) irq16_reg <= 1'b1; // see RULE2
            end
            // Edge capture: first edge always, later ones only when not ignored
            if (en16_reg & edge_hit & (armed_reg | ~ign16_reg)) begin // see RULE1
                cap_reg <= ~cnt16_reg; // see RULE19
                cnt16_reg <= reload16; // see RULE4, see RULE19
                cst16_reg <= 1'b1;
                armed_reg <= 1'b0; // see RULE4
                if (cien16_reg) irq16_reg <= 1'b1;
            end
        end

        // Ping-pong hand-over: each single-pass terminal count starts the other timer
        if (pp_on & ~demod_reg & term8 & mode8_reg) begin
            en16_reg <= 1'b1; // see RULE9, see RULE13
            out16_reg <= init16_reg; // see RULE9
            cnt16_reg <= reload16; // see RULE9
        end
        if (pp_on & term16 & ign16_reg) begin
            en8_reg <= 1'b1; // see RULE10, see RULE13
            out8_reg <= init8_reg; // see RULE8
            cnt8_reg <= init8_reg ? hi8_reg : lo8_reg; // see RULE10
        end
    end
end

// ----------------------------------------------------------------
// Outputs
// ----------------------------------------------------------------
assign prdata = prdata_reg;
assign pready = pready_reg;
assign pslverr = pslverr_reg;
assign short_timer_output = out8_reg;
assign long_timer_output = out16_reg;
assign short_timer_irq = irq8_reg;
assign long_timer_irq = irq16_reg;

endmodule // irt_timer_pair

`default_nettype wire

// ==== include/irt_defs.vh ====
/*
 * Shared constants of the infrared timer pair: register indexes,
 * field positions, mode codes and reset values.
 * Assumes inclusion by bare name from files under verilog/.
 */
`ifndef IRT_DEFS_VH
`define IRT_DEFS_VH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define IRT_IDX_CTL0 4'h0
`define IRT_IDX_CTL1 4'h1
`define IRT_IDX_CTL2 4'h2
`define IRT_IDX_AUX 4'h3
`define IRT_IDX_HI8 4'h4
`define IRT_IDX_LO8 4'h5
`define IRT_IDX_RH16 4'h6
`define IRT_IDX_RL16 4'h7
`define IRT_IDX_CAPH 4'h8
`define IRT_IDX_CAPL 4'h9
`define IRT_IDX_PRESC 4'ha
`define IRT_AW 6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IRT_B_EN 7
`define IRT_B_MODE 6
`define IRT_B_ST 5
`define IRT_B_CST 3
`define IRT_B_CIEN 2
`define IRT_B_IEN 1
`define IRT_B_DEMOD 6
`define IRT_B_ESEL_HI 5
`define IRT_B_ESEL_LO 4
`define IRT_B_PP_HI 3
`define IRT_B_PP_LO 2
`define IRT_B_INIT8 1
`define IRT_B_INIT16 0
`define IRT_B_AUX_EN16 7
`define IRT_B_AUX_EN8 6
`define IRT_B_SYNC 5

// ----------------------------------------------------------------
// Codes and values
// ----------------------------------------------------------------
`define IRT_PP_ON 2'b01
`define IRT_PP_OFF 2'b00
`define IRT_AUX_RSVD 5'h1f
`define IRT_ONE8 8'h01
`define IRT_ONE16 16'h0001
`define IRT_ZERO16 16'h0000
`define IRT_ALL16 16'hffff
`define IRT_RST8 8'h00
`define IRT_RST16 16'h0000

`endif

// ==== verilog/irt_edge_sync.v ====
/*
 * Carrier pin synchroniser and edge detector.
 * Assumes carrier_in is asynchronous to core_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module irt_edge_sync (
    input wire core_clk,
    input wire rst,
    input wire carrier_in,
    output wire rise,
    output wire fall
);

reg meta_reg;
reg sync_reg;
reg last_reg;
reg rise_reg;
reg fall_reg;

// ----------------------------------------------------------------
// Two stages, then a delayed copy for edge compare
// ----------------------------------------------------------------
// Only the second stage looks at the first, to keep metastability out
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
        last_reg <= 1'b0;
        rise_reg <= 1'b0;
        fall_reg <= 1'b0;
    end else begin
        meta_reg <= carrier_in;
        sync_reg <= meta_reg;
        last_reg <= sync_reg;
        rise_reg <= sync_reg & ~last_reg;
        fall_reg <= ~sync_reg & last_reg;
    end
end

assign rise = rise_reg;
assign fall = fall_reg;

endmodule // irt_edge_sync

`default_nettype wire

// ==== tb/irt_pair_monitor.sv ====
/* Checker for the timer pair: APB answer timing and irq output pulses.
   Assumes a bind to irt_timer_pair, one clock core_clk, async reset rst. */
`timescale 1ns/10ps
`default_nettype none
`include "irt_defs.vh"
module irt_pair_monitor (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic stop_recover,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`IRT_AW-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic short_timer_output,
    input wire logic long_timer_output,
    input wire logic short_timer_irq,
    input wire logic long_timer_irq
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // Setup phase of any transfer, and of a read of the aux register
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_aux_rd;
        s_setup ##0 (!pwrite && paddr == {`IRT_IDX_AUX, 2'b00});
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    // Unknown index or unaligned address is refused with zero data
    a_unmapped_refused: assert property (s_setup ##0
        (paddr[5:2] > `IRT_IDX_PRESC || paddr[1:0] != 2'b00) |=> pslverr && prdata == 32'h0)
        else $error("bad address not refused");
    a_aux_reserved_ones: assert property (s_aux_rd |=> prdata[4:0] == `IRT_AUX_RSVD)
        else $error("aux reserved bits not ones");
    a_short_irq_pulse: assert property (short_timer_irq |=> !short_timer_irq)
        else $error("short irq longer than one cycle");
    a_long_irq_pulse: assert property (long_timer_irq |=> !long_timer_irq)
        else $error("long irq longer than one cycle");
    // Stop recovery silences both outputs and both irqs
    a_stop_quiets: assert property (stop_recover |=> !short_timer_output && !long_timer_output
        && !short_timer_irq && !long_timer_irq)
        else $error("outputs active after stop recovery");
endmodule // irt_pair_monitor
bind irt_timer_pair irt_pair_monitor u_mon (.core_clk(core_clk), .rst(rst),
    .stop_recover(stop_recover), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .short_timer_output(short_timer_output), .long_timer_output(long_timer_output),
    .short_timer_irq(short_timer_irq), .long_timer_irq(long_timer_irq));
`default_nettype wire

// ==== tb/irt_carrier_model.sv ====
/* Carrier source on the far side: toggles while run, else holds level.
   Assumes the bench owns run and level; edges leave on clock edges. */
`timescale 1ns/10ps
`default_nettype none
module irt_carrier_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic level,
    input wire logic [7:0] half_period,
    output logic carrier_in
);
    logic [7:0] cnt_reg;
    // ------------------------------------------------------------
    // Burst generator
    // ------------------------------------------------------------
    // Single steps of level give lone edges for the arm tests
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            carrier_in <= 1'b0;
            cnt_reg <= 8'h00;
        end else if (!run) begin
            carrier_in <= level;
            cnt_reg <= 8'h00;
        end else if (cnt_reg == half_period) begin
            carrier_in <= !carrier_in;
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule // irt_carrier_model
`default_nettype wire

// ==== tb/test_irt_timer_pair.sv ====
/* Self-checking bench: APB register access, ping-pong and demodulation.
   Assumes zero-wait APB answers and the carrier model on carrier_in. */
`timescale 1ns/10ps
`default_nettype none
`include "irt_defs.vh"
module test_irt_timer_pair;
    localparam logic [5:0] A_C0 = {`IRT_IDX_CTL0, 2'b00}, A_C1 = {`IRT_IDX_CTL1, 2'b00};
    localparam logic [5:0] A_C2 = {`IRT_IDX_CTL2, 2'b00}, A_AUX = {`IRT_IDX_AUX, 2'b00};
    localparam logic [5:0] A_H8 = {`IRT_IDX_HI8, 2'b00}, A_L8 = {`IRT_IDX_LO8, 2'b00};
    localparam logic [5:0] A_RH = {`IRT_IDX_RH16, 2'b00}, A_RL = {`IRT_IDX_RL16, 2'b00};
    localparam logic [5:0] A_CH = {`IRT_IDX_CAPH, 2'b00}, A_CL = {`IRT_IDX_CAPL, 2'b00};
    logic core_clk, rst, stop_recover, psel, penable, pwrite, run, level, err;
    logic [`IRT_AW-1:0] paddr;
    logic [31:0] pwdata;
    logic [7:0] rd;
    logic [15:0] c1, c2;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, carrier_in, sto, lto, sirq, lirq;
    int err_count = 0, num_checks = 0, cyc = 0, s_cnt = 0, l_cnt = 0;
    int s_at, l_at, t0, s1, l0;
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    irt_timer_pair dut (.core_clk(core_clk), .rst(rst), .stop_recover(stop_recover),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .carrier_in(carrier_in),
        .short_timer_output(sto), .long_timer_output(lto), .short_timer_irq(sirq),
        .long_timer_irq(lirq));
    irt_carrier_model u_car (.core_clk(core_clk), .rst(rst), .run(run), .level(level),
        .half_period(8'h09), .carrier_in(carrier_in));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Irq pulses are counted with cycle stamps; a hang ends the run
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (sirq === 1'b1) begin
            s_cnt <= s_cnt + 1;
            s_at <= cyc;
        end
        if (lirq === 1'b1) begin
            l_cnt <= l_cnt + 1;
            l_at <= cyc;
        end
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task apb(input logic wr, input logic [5:0] ad, input logic [7:0] wd);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= {24'h000000, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(n < 50, 1'b1);
    endtask
    task wr(input logic [5:0] ad, input logic [7:0] wd);
        apb(1'b1, ad, wd);
    endtask
    task rdm(input logic [5:0] ad, input logic [7:0] mask, input logic [7:0] exp);
        apb(1'b0, ad, 8'h00);
        chk(rd & mask, exp);
    endtask
    task wait_irq(input logic lsel, input int target);
        int n;
        n = 0;
        while ((lsel ? l_cnt : s_cnt) < target && n < 1000) begin
            @(posedge core_clk);
            n++;
        end
        chk(n < 1000, 1'b1);
    endtask
    task pulse_stop;
        @(posedge core_clk);
        stop_recover <= 1'b1;
        @(posedge core_clk);
        stop_recover <= 1'b0;
    endtask
    // Fire the short timer once and read back the long capture
    task cap(output logic [15:0] c);
        int t;
        t = s_cnt;
        wr(A_C0, 8'hc2);
        wait_irq(1'b0, t + 1);
        repeat (4) @(posedge core_clk);
        apb(1'b0, A_CH, 8'h00);
        c[15:8] = rd;
        apb(1'b0, A_CL, 8'h00);
        c[7:0] = rd;
    endtask
    task complete_run;
        $display("Checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {stop_recover, psel, penable, pwrite, run, level} = 6'h00;
        paddr = 6'h00;
        pwdata = 32'h0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        rdm(A_AUX, 8'hff, 8'h1f);
        apb(1'b0, 6'h0d, 8'h00);
        chk({err, rd}, 9'h100);
        apb(1'b1, {4'hb, 2'b00}, 8'h00);
        chk(err, 1'b1);
        wr(A_AUX, 8'h20);
        rdm(A_AUX, 8'hff, 8'h3f);
        pulse_stop();
        rdm(A_AUX, 8'hff, 8'h3f);
        wr(A_H8, 8'h20);
        wr(A_AUX, 8'h60);
        rdm(A_AUX, 8'hff, 8'h7f);
        rdm(A_C0, 8'h80, 8'h80);
        wr(A_AUX, 8'h20);
        rdm(A_AUX, 8'hff, 8'h3f);
        // Ping-pong: high count 32, long reload 64, both start levels 1
        wr(A_L8, 8'h10);
        wr(A_RH, 8'h00);
        wr(A_RL, 8'h40);
        wr(A_C0, 8'h42);
        wr(A_C2, 8'h42);
        wr(A_C1, 8'h07);
        wr(A_C0, 8'hc2);
        t0 = cyc;
        repeat (2) @(posedge core_clk);
        chk(sto, 1'b1);
        wait_irq(1'b0, 1);
        chk(s_at - t0 >= 28 && s_at - t0 <= 38, 1'b1);
        rdm(A_AUX, 8'hff, 8'hbf);
        chk(lto, 1'b1);
        rdm(A_C0, 8'ha0, 8'h20);
        wait_irq(1'b1, 1);
        chk(l_at - s_at >= 60 && l_at - s_at <= 72, 1'b1);
        rdm(A_AUX, 8'hff, 8'h7f);
        rdm(A_C2, 8'ha0, 8'h20);
        wait_irq(1'b0, 2);
        wr(A_C1, 8'h00);
        repeat (300) @(posedge core_clk);
        chk(s_cnt, 2);
        rdm(A_AUX, 8'hff, 8'h3f);
        // Demodulation with ignore-edges set, carrier toggling
        pulse_stop();
        wr(A_RH, 8'h02);
        wr(A_RL, 8'h00);
        wr(A_H8, 8'h40);
        wr(A_L8, 8'h40);
        wr(A_C1, 8'h50);
        wr(A_C0, 8'h42);
        wr(A_C2, 8'hc6);
        run <= 1'b1;
        repeat (40) @(posedge core_clk);
        l0 = l_cnt;
        cap(c1);
        chk(l_cnt, l0 + 1);
        s1 = s_at;
        cap(c2);
        chk(c1 - c2, s_at - s1);
        wait_irq(1'b1, l_cnt + 1);
        rdm(A_C2, 8'h20, 8'h20);
        cap(c1);
        chk(c1[15:8], 8'hff);
        // Re-arm by writing 0 then 1, one lone rising and one lone falling edge per edge select code 1 to 3
        run <= 1'b0;
        level <= 1'b0;
        wr(A_RH, 8'hff);
        wr(A_RL, 8'hff);
        for (int e = 1; e < 4; e++) begin
            for (int d = 0; d < 2; d++) begin
                wr(A_C1, {2'b01, e[1:0], 4'h0});
                wr(A_C2, 8'h86);
                wr(A_C2, 8'hc6);
                l0 = l_cnt;
                level <= (d == 0);
                repeat (12) @(posedge core_clk);
                chk(l_cnt - l0, (d == 0) ? e[0] : e[1]);
            end
        end
        l0 = l_cnt;
        level <= 1'b1;
        repeat (12) @(posedge core_clk);
        chk(l_cnt - l0, 0);
        rdm(A_C2, 8'h08, 8'h08);
        complete_run();
    end
endmodule // test_irt_timer_pair
`default_nettype wire
